// ---- src/bram_guard_regs.svh ----
// reset values and synchroniser depth for the block memory reset guard
// assumes inclusion by bare name from src/
`ifndef BRAM_GUARD_REGS_SVH
`define BRAM_GUARD_REGS_SVH

`define BRG_SEQ_ERR_RST 1'b0
`define BRG_SYNC_STAGES 2
`define BRG_DEF_DATA_W 9
`define BRG_DEF_ADDR_W 10

`endif

// ---- src/bram_guard_pkg.sv ----
// types shared by the block memory and its reset guard
// assumes nothing of its surroundings
package bram_guard_pkg;
    typedef enum {MODE_RAM, MODE_ROM, MODE_FIFO} mem_mode_t;
endpackage

// ---- src/mem_array.sv ----
// flip-flop storage array, one write port and one combinational read port
// assumes a single clock; rom contents come from the init vector
`timescale 1ns/1ps
`default_nettype none

module mem_array #(
    parameter int DATA_W = 9,
    parameter int ADDR_W = 10,
    parameter bit IS_ROM = 1'b0,
    parameter logic [DATA_W*(2**ADDR_W)-1:0] INIT = '0
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    // read side
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    localparam int DEPTH = 2**ADDR_W;

    generate
        if (IS_ROM) begin : g_rom
            // contents fixed at configuration, nothing to write
            assign rdata = INIT[raddr*DATA_W +: DATA_W];
        end else begin : g_ram
            logic [DATA_W-1:0] word_r [DEPTH];
            for (genvar i = 0; i < DEPTH; i++) begin : g_word
                always_ff @(posedge clk) begin
                    if (we && waddr == ADDR_W'(i)) begin
                        word_r[i] <= wdata;
                    end
                end
            end
            assign rdata = word_r[raddr];
        end
    endgenerate
endmodule // mem_array

`default_nettype wire

// ---- src/block_ram_async_reset_guard.sv ----
// block memory (ram, rom or fifo) with its reset paths and a sequence monitor
// assumes fabric logic on CORE_CLK drives enables; reset pins may be asynchronous
//
// Operation
// - global set/reset acts on the memory asynchronously in fifo mode, and in ram and rom only when SET_RESET_USED is set
// - fifo mode: global set/reset always connected, write/read enables act as enables
// - fifo read pointer clear, and full reset unless USE_SYNC_RESET is set, take effect without a clock edge
// - synchronous reset with global set/reset disabled carries no ordering limits
// - the same full/async reset sequencing holds for ram, rom and fifo; fifo alone also checks read pointer clear
`timescale 1ns/1ps
`default_nettype none
`include "bram_guard_regs.svh"

module block_ram_async_reset_guard
    import bram_guard_pkg::*;
#(
    parameter mem_mode_t MODE = MODE_RAM,
    parameter int DATA_W = `BRG_DEF_DATA_W,
    parameter int ADDR_W = `BRG_DEF_ADDR_W,
    parameter bit SET_RESET_USED = 1'b1,
    parameter bit USE_SYNC_RESET = 1'b0,
    parameter logic [DATA_W*(2**ADDR_W)-1:0] INIT = '0
) (
    // clock and fabric reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // memory resets
    input wire logic GLOBAL_SET_RESET,
    input wire logic MEM_RESET,
    input wire logic READ_POINTER_CLEAR,
    // write side
    input wire logic WRITE_ENABLE,
    input wire logic [ADDR_W-1:0] WRITE_ADDR,
    input wire logic [DATA_W-1:0] WRITE_DATA,
    // read side
    input wire logic READ_ENABLE,
    input wire logic [ADDR_W-1:0] READ_ADDR,
    output logic [DATA_W-1:0] READ_DATA,
    // fifo flags
    output logic FIFO_EMPTY,
    output logic FIFO_FULL,
    // sequencing status
    output logic SEQ_ERROR
);
    localparam int DEPTH = 2**ADDR_W;
    localparam bit IS_FIFO = (MODE == MODE_FIFO);

    if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 14) begin : g_bad_size
        $error("block memory size out of range");
    end
    if (MODE == MODE_ROM && USE_SYNC_RESET && !SET_RESET_USED) begin : g_rom_ok
    end

    // reset paths
    logic sr_conn;
    logic sr_active;
    logic core_arst;
    logic rp_arst;
    logic sync_hit;
    assign sr_conn = SET_RESET_USED || IS_FIFO;
    assign sr_active = GLOBAL_SET_RESET & sr_conn;
    assign core_arst = sr_active | (MEM_RESET & ~USE_SYNC_RESET);
    assign rp_arst = core_arst | (READ_POINTER_CLEAR & IS_FIFO);
    assign sync_hit = MEM_RESET & USE_SYNC_RESET;

    // fifo pointers carry one extra bit to tell full from empty
    logic [ADDR_W:0] wr_ptr_r;
    logic [ADDR_W:0] rd_ptr_r;
    logic [ADDR_W:0] count;
    logic wr_fire;
    logic rd_fire;
    logic mem_we;
    logic [ADDR_W-1:0] mem_waddr;
    logic [ADDR_W-1:0] mem_raddr;
    logic [DATA_W-1:0] mem_q;

    assign count = wr_ptr_r - rd_ptr_r;
    assign FIFO_EMPTY = IS_FIFO && (count == '0);
    assign FIFO_FULL = IS_FIFO && (count == (ADDR_W+1)'(DEPTH));
    // fifo: write and read enables stand in for the clock enables
    assign wr_fire = IS_FIFO ? (WRITE_ENABLE & ~FIFO_FULL) : WRITE_ENABLE;
    assign rd_fire = IS_FIFO ? (READ_ENABLE & ~FIFO_EMPTY) : READ_ENABLE;
    assign mem_we = wr_fire && (MODE != MODE_ROM);
    assign mem_waddr = IS_FIFO ? wr_ptr_r[ADDR_W-1:0] : WRITE_ADDR;
    assign mem_raddr = IS_FIFO ? rd_ptr_r[ADDR_W-1:0] : READ_ADDR;

    mem_array #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W),
        .IS_ROM(MODE == MODE_ROM),
        .INIT(INIT)
    ) u_array (
        .clk(CORE_CLK),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(WRITE_DATA),
        .raddr(mem_raddr),
        .rdata(mem_q)
    );

    // full reset clears both pointers at once, no clock needed unless USE_SYNC_RESET is set
    always_ff @(posedge CORE_CLK or posedge core_arst) begin
        if (core_arst) begin
            wr_ptr_r <= '0;
        end else if (RESET || sync_hit) begin
            wr_ptr_r <= '0;
        end else if (IS_FIFO && wr_fire) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // read pointer clear rewinds reads only, written data stays
    always_ff @(posedge CORE_CLK or posedge rp_arst) begin
        if (rp_arst) begin
            rd_ptr_r <= '0;
        end else if (RESET || sync_hit) begin
            rd_ptr_r <= '0;
        end else if (IS_FIFO && rd_fire) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // output register: async clear, or sync clear when that style is chosen
    always_ff @(posedge CORE_CLK or posedge core_arst) begin
        if (core_arst) begin
            READ_DATA <= '0;
        end else if (sync_hit) begin
            READ_DATA <= '0;
        end else if (rd_fire) begin
            READ_DATA <= mem_q;
        end
    end

    // sequence monitor: source 0 full/async reset, source 1 read pointer clear.
    // pins are resynchronised, so enables are delayed to line up; the check
    // is only as sharp as the synchroniser, about one cycle either way.
    logic [1:0] src_pin;
    logic [1:0] src_watch;
    logic [1:0] src_en;
    logic [1:0] viol;
    assign src_pin = {READ_POINTER_CLEAR & IS_FIFO, core_arst};
    // synchronous-only reset with set/reset off needs no ordering check
    assign src_watch = {IS_FIFO, !(USE_SYNC_RESET && !sr_conn)};
    // fifo: full reset against both enables, pointer clear against read only
    assign src_en = {READ_ENABLE, WRITE_ENABLE | READ_ENABLE};

    for (genvar s = 0; s < 2; s++) begin : g_mon
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic en_d1_r;
        logic en_d2_r;
        logic en_d3_r;
        logic pre_bad;
        logic hold_bad;
        always_ff @(posedge CORE_CLK) begin
            if (RESET) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                s3_r <= 1'b0;
                en_d1_r <= 1'b0;
                en_d2_r <= 1'b0;
                en_d3_r <= 1'b0;
            end else begin
                s1_r <= src_pin[s];
                s2_r <= s1_r;
                s3_r <= s2_r;
                en_d1_r <= src_en[s];
                en_d2_r <= en_d1_r;
                en_d3_r <= en_d2_r;
            end
        end
        assign pre_bad = s2_r & ~s3_r & en_d3_r;
        assign hold_bad = (s2_r | s3_r) & en_d2_r;
        assign viol[s] = src_watch[s] & (pre_bad | hold_bad);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            SEQ_ERROR <= `BRG_SEQ_ERR_RST;
        end else if (|viol) begin
            SEQ_ERROR <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    property p_sr_clears_out;
        sr_active |-> (READ_DATA == '0) && (!IS_FIFO || FIFO_EMPTY);
    endproperty
    a_sr_clears_out: assert property (p_sr_clears_out) else $error("set/reset left data");

    property p_fifo_sr_forced;
        (IS_FIFO && GLOBAL_SET_RESET) |-> FIFO_EMPTY && !FIFO_FULL && wr_ptr_r == '0;
    endproperty
    a_fifo_sr_forced: assert property (p_fifo_sr_forced) else $error("fifo not cleared");

    property p_rp_clear;
        (IS_FIFO && READ_POINTER_CLEAR) |-> rd_ptr_r == '0 ##1 (READ_POINTER_CLEAR || rd_ptr_r <= 1);
    endproperty
    a_rp_clear: assert property (p_rp_clear) else $error("read pointer not cleared");

    property p_full_reset;
        (IS_FIFO && MEM_RESET && !USE_SYNC_RESET) |-> FIFO_EMPTY && READ_DATA == '0;
    endproperty
    a_full_reset: assert property (p_full_reset) else $error("full reset not immediate");

    property p_sync_reset;
        (sync_hit && !core_arst) |=> READ_DATA == '0 && wr_ptr_r == '0;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("sync reset missed");

    property p_seq_flag;
        (|viol) |=> SEQ_ERROR [*3];
    endproperty
    a_seq_flag: assert property (p_seq_flag) else $error("violation not flagged");

    // judged from the raw pins, so a broken synchroniser chain shows up
    property p_seq_hold;
        (src_watch[0] && core_arst && $past(core_arst) && src_en[0]) |-> ##[1:4] SEQ_ERROR;
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("early enable not flagged");

    property p_fifo_count;
        (IS_FIFO && wr_fire && !rd_fire && !rp_arst && !sync_hit) ##1 !rp_arst
            |-> count == $past(count) + 1'b1;
    endproperty
    a_fifo_count: assert property (p_fifo_count) else $error("fifo count wrong");

endmodule // block_ram_async_reset_guard

`default_nettype wire

// ---- verif/fabric_model.sv ----
// fabric-side partner: drives memory enables, data and reset pins
// assumes bench calls its tasks; all changes land at falling edges
`timescale 1ns/1ps
`default_nettype none

module fabric_model (
    // clock
    input wire logic clk,
    // reset pins
    output logic set_rst,
    output logic mrst,
    output logic rpc,
    // data side
    output logic we,
    output logic re,
    output logic [9:0] wa,
    output logic [9:0] ra,
    output logic [8:0] wd
);
    initial begin
        {set_rst, mrst, rpc, we, re} = 5'h00;
        wa = 10'h000;
        ra = 10'h000;
        wd = 9'h000;
    end
    task automatic write(input logic [9:0] a, input logic [8:0] d);
        @(negedge clk);
        we = 1'b1;
        wa = a;
        wd = d;
        @(negedge clk);
        we = 1'b0;
        wd = ~d; // released bus, never the old word
    endtask
    task automatic read(input logic [9:0] a);
        @(negedge clk);
        re = 1'b1;
        ra = a;
        @(negedge clk);
        re = 1'b0;
        ra = ~a;
    endtask
    // pins is {set/reset, memory reset, pointer clear}; enables already low
    task automatic reset_on(input logic [2:0] pins);
        repeat (2) @(negedge clk);
        {set_rst, mrst, rpc} = pins;
        #1; // off-edge, so the effect needs no clock
    endtask
    task automatic reset_off(input logic [2:0] pins);
        repeat (3) @(negedge clk);
        {set_rst, mrst, rpc} = {set_rst, mrst, rpc} & ~pins;
        repeat (2) @(negedge clk);
    endtask
endmodule // fabric_model

`default_nettype wire

// ---- verif/test_block_ram_async_reset_guard.sv ----
// bench: ram, fifo, sync-reset ram and rom copies of the guard fed by one fabric model
// assumes the sources under src/ are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h", $time, (a)); end end

module test_block_ram_async_reset_guard;
    import bram_guard_pkg::*;
    logic CORE_CLK, RESET, set_rst, mrst, rpc, we, re;
    logic [9:0] wa, ra;
    logic [8:0] wd, rd_ram, rd_fifo, rd_sync, rd_rom;
    logic emp_fifo, full_fifo, err_ram, err_fifo, err_sync, err_rom;
    logic emp_ram, full_ram, emp_sync, full_sync, emp_rom, full_rom;
    // rom word 1 holds 9'h0a5, every other word zero
    localparam logic [9215:0] ROM_INIT = 9216'h14a00;
    int err_total = 0;
    int compares = 0;

    fabric_model fabric_model_inst (.clk(CORE_CLK), .set_rst(set_rst), .mrst(mrst), .rpc(rpc),
        .we(we), .re(re), .wa(wa), .ra(ra), .wd(wd));
    block_ram_async_reset_guard block_ram_async_reset_guard_inst (.CORE_CLK(CORE_CLK),
        .RESET(RESET), .GLOBAL_SET_RESET(set_rst), .MEM_RESET(mrst), .READ_POINTER_CLEAR(rpc),
        .WRITE_ENABLE(we), .WRITE_ADDR(wa), .WRITE_DATA(wd), .READ_ENABLE(re),
        .READ_ADDR(ra), .READ_DATA(rd_ram), .FIFO_EMPTY(emp_ram), .FIFO_FULL(full_ram),
        .SEQ_ERROR(err_ram));
    block_ram_async_reset_guard #(.MODE(MODE_FIFO)) block_ram_async_reset_guard_fifo_inst (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .GLOBAL_SET_RESET(set_rst), .MEM_RESET(mrst),
        .READ_POINTER_CLEAR(rpc), .WRITE_ENABLE(we), .WRITE_ADDR(wa), .WRITE_DATA(wd),
        .READ_ENABLE(re), .READ_ADDR(ra), .READ_DATA(rd_fifo), .FIFO_EMPTY(emp_fifo),
        .FIFO_FULL(full_fifo), .SEQ_ERROR(err_fifo));
    // sync reset with set/reset off: no ordering limits, monitor stays quiet
    block_ram_async_reset_guard #(.SET_RESET_USED(1'b0), .USE_SYNC_RESET(1'b1))
        block_ram_async_reset_guard_sync_inst (.CORE_CLK(CORE_CLK), .RESET(RESET),
        .GLOBAL_SET_RESET(set_rst), .MEM_RESET(mrst), .READ_POINTER_CLEAR(rpc),
        .WRITE_ENABLE(we), .WRITE_ADDR(wa), .WRITE_DATA(wd), .READ_ENABLE(re),
        .READ_ADDR(ra), .READ_DATA(rd_sync), .FIFO_EMPTY(emp_sync), .FIFO_FULL(full_sync),
        .SEQ_ERROR(err_sync));
    // preloaded rom keeps set/reset off; its memory reset stays async, so its order is still checked
    block_ram_async_reset_guard #(.MODE(MODE_ROM), .SET_RESET_USED(1'b0),
        .INIT(ROM_INIT)) block_ram_async_reset_guard_rom_inst (.CORE_CLK(CORE_CLK),
        .RESET(RESET), .GLOBAL_SET_RESET(set_rst), .MEM_RESET(mrst), .READ_POINTER_CLEAR(rpc),
        .WRITE_ENABLE(we), .WRITE_ADDR(wa), .WRITE_DATA(wd), .READ_ENABLE(re),
        .READ_ADDR(ra), .READ_DATA(rd_rom), .FIFO_EMPTY(emp_rom), .FIFO_FULL(full_rom),
        .SEQ_ERROR(err_rom));

    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_ram_fifo();
        fabric_model_inst.write(10'h003, 9'h1a5);
        fabric_model_inst.write(10'h004, 9'h05a);
        `CHK(emp_fifo, 1'b0);
        fabric_model_inst.read(10'h003);
        `CHK(rd_ram, 9'h1a5);
        `CHK(rd_fifo, 9'h1a5);
        fabric_model_inst.read(10'h004);
        `CHK(rd_fifo, 9'h05a);
        `CHK(emp_fifo, 1'b1);
    endtask

    // clear rewinds only the read side: oldest stored word comes back
    task automatic t_ptr_clear();
        fabric_model_inst.write(10'h005, 9'h0c3);
        fabric_model_inst.write(10'h006, 9'h03c);
        fabric_model_inst.read(10'h000);
        `CHK(rd_fifo, 9'h0c3);
        fabric_model_inst.reset_on(3'h1);
        fabric_model_inst.reset_off(3'h1);
        fabric_model_inst.read(10'h000);
        `CHK(rd_fifo, 9'h1a5);
    endtask

    task automatic t_async();
        fabric_model_inst.read(10'h006);
        `CHK(rd_ram, 9'h03c);
        fabric_model_inst.reset_on(3'h4);
        `CHK(rd_ram, 9'h000);
        `CHK(rd_sync, 9'h03c);
        `CHK(emp_fifo, 1'b1);
        fabric_model_inst.reset_off(3'h4);
        fabric_model_inst.read(10'h005);
        fabric_model_inst.reset_on(3'h2);
        `CHK(rd_ram, 9'h000);
        `CHK(rd_sync, 9'h0c3);
        fabric_model_inst.reset_off(3'h2);
        `CHK(rd_sync, 9'h000);
        `CHK({err_sync, err_rom}, 2'b00);
        `CHK(err_ram, 1'b0);
        `CHK(err_fifo, 1'b0);
    endtask

    // read enable raised inside the reset window must be flagged
    task automatic t_violation();
        fabric_model_inst.reset_on(3'h2);
        fabric_model_inst.read(10'h005);
        fabric_model_inst.reset_off(3'h2);
        repeat (6) @(negedge CORE_CLK);
        `CHK(err_ram, 1'b1);
        `CHK(err_fifo, 1'b1);
        `CHK(err_rom, 1'b1);
        `CHK(err_sync, 1'b0);
        RESET = 1'b1;
        @(negedge CORE_CLK);
        RESET = 1'b0;
        `CHK(err_ram, 1'b0);
    endtask

    // rom ignores writes and serves its preloaded word
    task automatic t_rom();
        fabric_model_inst.write(10'h001, 9'h111);
        fabric_model_inst.read(10'h001);
        `CHK(rd_rom, 9'h0a5);
        `CHK(rd_fifo, 9'h111);
    endtask

    // fill the fifo; a refused push must not overwrite the oldest word
    task automatic t_full();
        for (int i = 0; i < 1024; i++) begin
            fabric_model_inst.write(10'(i), 9'(i) ^ 9'h155);
        end
        `CHK(full_fifo, 1'b1);
        `CHK(emp_fifo, 1'b0);
        `CHK({emp_ram, full_ram, emp_sync, full_sync, emp_rom, full_rom}, 6'h00);
        fabric_model_inst.write(10'h000, 9'h0aa);
        fabric_model_inst.read(10'h000);
        `CHK(rd_fifo, 9'h155);
        `CHK(full_fifo, 1'b0);
    endtask

    initial begin
        RESET = 1'b1;
        repeat (16) @(negedge CORE_CLK);
        RESET = 1'b0;
        `CHK(emp_fifo, 1'b1);
        t_ram_fifo();
        t_ptr_clear();
        t_async();
        t_violation();
        t_rom();
        t_full();
        wrap_up();
    end

    // run needs about 2130 cycles, mostly the fifo fill
    initial begin
        #40000;
        err_total++;
        wrap_up();
    end
endmodule // test_block_ram_async_reset_guard

`default_nettype wire
